// [sim/bank_phase_source.sv]
// Far-side stand-in: the bank dividers and board feedback that make the phase levels.
// Assumes sys_clk drives it; bank 0 toggles every cycle, slow doubles banks 1 to 4.
`timescale 1ns/1ps
`default_nettype none
module bank_phase_source (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       slow,
  output var  logic [4:0] phase
);
  logic [4:0][3:0] cnt_q;
  always_ff @(posedge sys_clk) begin
    for (int b = 0; b < 5; b++) begin
      // Half period b+1 cycles, 2b+2 for banks 1 to 4 when slow; bank 4 stands for a zero-skew feedback output.
      if (!rst_n || cnt_q[b] == 4'(b == 0 || !slow ? b : 2 * b + 1)) begin
        cnt_q[b] <= 4'h0;
        phase[b] <= rst_n ? !phase[b] : 1'b0;
      end else begin
        cnt_q[b] <= cnt_q[b] + 4'h1;
      end
    end
  end
endmodule : bank_phase_source
`default_nettype wire

// [sim/clock_bank_disable_control_assertions.sv]
// Checker watching the top ports of the bank disable control.
// Assumes the phase of bank 0 toggles every cycle.
`timescale 1ns/1ps
`default_nettype none
module clock_bank_disable_control_assertions (
  input wire logic                          sys_clk,
  input wire logic                          rst_n,
  input wire logic [3:0]                    bank_disable_in,
  input wire logic                          feedback_bank_disable_in,
  input wire logic                          output_mode_high_in,
  input wire logic                          output_mode_mid_in,
  input wire logic                          ref_test_level_in,
  input wire logic [4:0]                    bank_phase_in,
  input wire logic [3:0][3:0]               output_invert,
  input wire clk_bank_pkg::lvl_t [3:0][1:0] bank_skew_select,
  input wire clk_bank_pkg::lvl_t            feedback_skew_select,
  input wire clk_bank_pkg::lvl_t [4:0][1:0] bank_divide_select,
  input wire logic [3:0][3:0]               bank_clk_out,
  input wire logic [3:0][3:0]               bank_clk_oe_n,
  input wire logic [1:0]                    feedback_clk_out,
  input wire logic [1:0]                    feedback_clk_oe_n,
  input wire clk_bank_pkg::skew_t [4:0]     skew_offset_tu,
  input wire logic [4:0]                    bank_at_nominal,
  input wire logic                          factory_test_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic run0, hold0, hiz0;
  assign run0 = !output_mode_mid_in && !bank_disable_in[0];
  assign hold0 = !output_mode_mid_in && !output_mode_high_in && bank_disable_in[0];
  assign hiz0 = !output_mode_mid_in && output_mode_high_in && bank_disable_in[0];
  a_run_follows: assert property (run0 [*6] |-> bank_clk_oe_n[0] == 4'h0 &&
    bank_clk_out[0] == ({4{$past(bank_phase_in[0])}} ^ $past(output_invert[0])))
    else $error("bank 0 not following its phase");
  a_hiz_release: assert property (hiz0 [*4] |-> bank_clk_oe_n[0] == 4'hF)
    else $error("bank 0 not released");
  a_hold_park: assert property (hold0 [*4] ##0 !bank_phase_in[0] |=>
    bank_clk_oe_n[0] == 4'h0 && bank_clk_out[0] == $past(output_invert[0]))
    else $error("bank 0 not parked at its idle level");
  a_hold_bound: assert property (hold0 [*6] |-> bank_clk_out[0] == $past(output_invert[0]))
    else $error("bank 0 hold-off too slow");
  a_test_flag: assert property (factory_test_active == $past(output_mode_mid_in, 3))
    else $error("test flag wrong");
  a_test_level: assert property ((output_mode_mid_in && ref_test_level_in) [*4] |->
    bank_clk_oe_n[1] == 4'h0 && bank_clk_out[1] == ~$past(output_invert[1]))
    else $error("bank 1 not showing the test level");
  a_follow_first: assert property (bank_skew_select[2] == 4'h4 |=>
    skew_offset_tu[2] == skew_offset_tu[0]) else $error("bank 2 not following bank 0");
  a_follow_second: assert property (bank_skew_select[3] == 4'h6 |=>
    skew_offset_tu[3] == skew_offset_tu[1]) else $error("bank 3 not following bank 1");
  a_fb_shift: assert property (feedback_skew_select == 2'h0 && bank_skew_select[0] == 4'h5 |=>
    skew_offset_tu[0] == 5'sh04) else $error("skew not shifted by feedback");
  a_nominal_fb: assert property (bank_divide_select[4] == 4'h0 |=> bank_at_nominal[4])
    else $error("feedback bank not at nominal");
  a_divided_first: assert property (bank_divide_select[0] != 4'h0 |=> !bank_at_nominal[0])
    else $error("divided bank 0 shown at nominal");
  c_hold: cover property (hold0 [*6]);
  c_hiz: cover property (hiz0 [*4]);
  c_test: cover property (output_mode_mid_in [*4]);
endmodule : clock_bank_disable_control_assertions
bind clock_bank_disable_control clock_bank_disable_control_assertions
  u_clock_bank_disable_control_assertions (.*);
`default_nettype wire

// [sim/clock_bank_disable_control_bench.sv]
// Self-checking bench: disables each bank in both styles, factory test, skew table.
// Assumes the checker is bound in and the phase source models the dividers.
`timescale 1ns/1ps
`default_nettype none
module clock_bank_disable_control_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic feedback_bank_disable_in, output_mode_high_in, output_mode_mid_in, ref_test_level_in;
  logic slow, factory_test_active, hz;
  logic [3:0] bank_disable_in;
  logic [4:0] bank_phase_in, ph_q, bank_at_nominal;
  logic [1:0] feedback_clk_out, feedback_clk_oe_n;
  logic [3:0][3:0] output_invert, bank_clk_out, bank_clk_oe_n;
  clk_bank_pkg::lvl_t [3:0][1:0] bank_skew_select;
  clk_bank_pkg::lvl_t feedback_skew_select;
  clk_bank_pkg::lvl_t [4:0][1:0] bank_divide_select;
  clk_bank_pkg::skew_t [4:0] skew_offset_tu;
  logic [31:0] seed = 32'h3EF04C2D;
  int fails = 0, checks_done = 0, cyc = 0;
  bank_phase_source u_bank_phase_source (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
    .phase(bank_phase_in));
  clock_bank_disable_control u_clock_bank_disable_control (.*);
  always #12.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  function automatic int far_raw(input int i, input int r0, input int r1);
    return i < 3 ? i - 8 : i == 3 ? r0 : i == 4 ? 0 : i == 5 ? r1 : i;
  endfunction : far_raw
  task automatic give_verdict;
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_skew(input clk_bank_pkg::skew_t got, input int exp);
    chk(16'(got), 16'(exp));
  endtask : chk_skew
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_n
  always @(posedge sys_clk) begin
    ph_q <= bank_phase_in;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    int b, r0, r1, fr, fbl, ix[5];
    {bank_disable_in, feedback_bank_disable_in, output_mode_high_in, slow} = '0;
    {output_mode_mid_in, ref_test_level_in, output_invert, bank_skew_select} = '0;
    feedback_skew_select = 2'h1;
    bank_divide_select = '0;
    wait_n(16);
    rst_n = 1'b1;
    wait_n(8);
    for (int k = 0; k < 20; k++) begin
      b = k % 5;
      hz = 1'((k / 5) % 2);
      slow = k >= 10;
      output_invert = 16'(rnd());
      output_mode_high_in = hz;
      wait_n(4);
      if (b == 4) feedback_bank_disable_in = 1'b1;
      else bank_disable_in[b] = 1'b1;
      wait_n(hz ? 3 : 24);
      chk(bank_clk_oe_n, hz && b < 4 ? 16'hF << 4 * b : 16'h0);
      chk(16'(feedback_clk_oe_n), hz && b == 4 ? 16'h3 : 16'h0);
      if (!hz && b < 4) chk(16'(bank_clk_out[b]), 16'(output_invert[b]));
      if (!hz && b == 4) chk(16'(feedback_clk_out), 16'h0);
      {bank_disable_in, feedback_bank_disable_in} = '0;
      wait_n(24);
      chk(bank_clk_oe_n, 16'h0);
      chk(16'(feedback_clk_oe_n), 16'h0);
      for (int j = 0; j < 4; j++) chk(16'(bank_clk_out[j]), 16'({4{ph_q[j]}} ^ output_invert[j]));
      chk(16'(feedback_clk_out), 16'({2{ph_q[4]}}));
    end
    for (int j = 0; j < 4; j++) begin
      output_mode_mid_in = 1'b1;
      ref_test_level_in = j == 0 || rnd() % 2;
      {bank_disable_in, feedback_bank_disable_in} = 5'(rnd());
      wait_n(4);
      chk(16'(factory_test_active), 16'h1);
      chk(bank_clk_oe_n, 16'h0);
      chk(bank_clk_out ^ output_invert, {16{ref_test_level_in}});
      chk(16'(feedback_clk_out), 16'({2{ref_test_level_in}}));
      {output_mode_mid_in, bank_disable_in, feedback_bank_disable_in} = '0;
      wait_n(24);
    end
    for (int k = 0; k < 30; k++) begin
      for (int j = 0; j < 5; j++) ix[j] = rnd() % 9;
      fbl = rnd() % 3;
      if (k < 9) {ix[2], ix[3]} = {k, 8 - k};
      if (k == 0) {ix[0], fbl} = {4, 0};
      for (int j = 0; j < 4; j++) bank_skew_select[j] = {2'(ix[j] / 3), 2'(ix[j] % 3)};
      for (int j = 0; j < 5; j++) bank_divide_select[j] = k % 2 ? 4'h0 : {2'(rnd() % 3), 2'(rnd() % 3)};
      feedback_skew_select = 2'(fbl);
      wait_n(2);
      r0 = ix[0] - 4;
      r1 = ix[1] - 4;
      fr = (fbl - 1) * 4;
      chk_skew(skew_offset_tu[0], r0 - fr);
      chk_skew(skew_offset_tu[1], r1 - fr);
      chk_skew(skew_offset_tu[2], far_raw(ix[2], r0, r1) - fr);
      chk_skew(skew_offset_tu[3], far_raw(ix[3], r0, r1) - fr);
      chk_skew(skew_offset_tu[4], 0);
      for (int j = 0; j < 5; j++) chk(16'(bank_at_nominal[j]), 16'(bank_divide_select[j] == 4'h0));
    end
    give_verdict();
  end
endmodule : clock_bank_disable_control_bench
`default_nettype wire

// [verilog/bank_gate.sv]
// One output bank gate: enables, parks glitch-free, or releases its outputs.
// Assumes every input is already in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none

module bank_gate #(
  parameter int N = 4
) (
  input  wire  logic         sys_clk,
  input  wire  logic         rst_n,
  input  wire  logic         phase,
  input  wire  logic         disable_req,
  input  wire  logic         high_z_style,
  input  wire  logic         test_mode,
  input  wire  logic         test_level,
  input  wire  logic [N-1:0] invert,
  output var   logic [N-1:0] q,
  output var   logic [N-1:0] oe_n
);

  typedef struct packed {
    clk_bank_pkg::gate_state_e state;
    logic [N-1:0]              q;
    logic [N-1:0]              oe_n;
  } gate_s;

  gate_s cur_q;
  gate_s nxt_d;

  always_comb begin
    nxt_d = cur_q;
    case (cur_q.state)
      clk_bank_pkg::GATE_RUN: begin
        if (disable_req && high_z_style) begin
          nxt_d.state = clk_bank_pkg::GATE_HIGH_Z;
        end else if (disable_req && !phase) begin
          // Parking only once the bank clock is low keeps the last pulse whole.
          nxt_d.state = clk_bank_pkg::GATE_PARKED;
        end
      end
      clk_bank_pkg::GATE_PARKED: begin
        if (disable_req && high_z_style) begin
          nxt_d.state = clk_bank_pkg::GATE_HIGH_Z;
        end else if (!disable_req && !phase) begin
          // Restart only while the clock is low, so the first edge is a full rise.
          nxt_d.state = clk_bank_pkg::GATE_RUN;
        end
      end
      clk_bank_pkg::GATE_HIGH_Z: begin
        if (!disable_req && !phase) begin
          nxt_d.state = clk_bank_pkg::GATE_RUN;
        end else if (disable_req && !high_z_style && !phase) begin
          nxt_d.state = clk_bank_pkg::GATE_PARKED;
        end
      end
      clk_bank_pkg::GATE_TEST: begin
        nxt_d.state = clk_bank_pkg::GATE_RUN;
      end
      default: begin
        nxt_d.state = clk_bank_pkg::GATE_RUN;
      end
    endcase
    if (test_mode) begin
      nxt_d.state = clk_bank_pkg::GATE_TEST;
    end
    case (nxt_d.state)
      clk_bank_pkg::GATE_RUN: begin
        nxt_d.q    = {N{phase}} ^ invert;
        nxt_d.oe_n = '0;
      end
      clk_bank_pkg::GATE_PARKED: begin
        // Non-inverting outputs rest low, inverting ones rest high.
        nxt_d.q    = invert;
        nxt_d.oe_n = '0;
      end
      clk_bank_pkg::GATE_HIGH_Z: begin
        nxt_d.q    = '0;
        nxt_d.oe_n = '1;
      end
      clk_bank_pkg::GATE_TEST: begin
        nxt_d.q    = {N{test_level}} ^ invert;
        nxt_d.oe_n = '0;
      end
      default: begin
        nxt_d.q    = '0;
        nxt_d.oe_n = '1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur_q.state <= clk_bank_pkg::GATE_RUN;
      cur_q.q     <= '0;
      cur_q.oe_n  <= '1;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign q    = cur_q.q;
  assign oe_n = cur_q.oe_n;

endmodule : bank_gate

`default_nettype wire

// [verilog/clk_bank_pkg.sv]
// Shared constants for the clock bank disable control.
// Assumes three-level pins arrive already encoded as two-bit level codes.
package clk_bank_pkg;

  localparam int NUM_BANKS     = 4;
  localparam int BANK_OUTS     = 4;
  localparam int FB_OUTS       = 2;
  localparam int ALL_BANKS     = 5;
  localparam int FB_BANK       = 4;
  localparam int SKEW_W        = 5;
  localparam int HOLDOFF_LIMIT = 6;

  typedef logic [1:0] lvl_t;
  localparam lvl_t LVL_LOW  = 2'h0;
  localparam lvl_t LVL_MID  = 2'h1;
  localparam lvl_t LVL_HIGH = 2'h2;

  typedef logic signed [SKEW_W-1:0] skew_t;

  // Base offset, in time units, for a select pair on the first two banks; the pair index adds to it.
  localparam skew_t SKEW_NEAR_BASE = 5'sh1C;
  // Offsets of the outer banks, indexed by the select pair.
  localparam skew_t SKEW_FAR [9] = '{5'sh18, 5'sh19, 5'sh1A, 5'sh00, 5'sh00,
                                     5'sh00, 5'sh06, 5'sh07, 5'sh08};
  localparam skew_t SKEW_FB_LOW  = 5'sh1C;
  localparam skew_t SKEW_FB_HIGH = 5'sh04;
  localparam skew_t SKEW_ZERO    = 5'sh00;

  typedef enum logic [1:0] {
    GATE_RUN,
    GATE_PARKED,
    GATE_HIGH_Z,
    GATE_TEST
  } gate_state_e;

  function automatic logic [3:0] skew_index(input lvl_t f1, input lvl_t f0);
    skew_index = 4'(f1 * 3 + f0);
  endfunction : skew_index

endpackage : clk_bank_pkg

// [verilog/clock_bank_disable_control.sv]
// Top of the bank disable control: pin synchronisers, skew resolution and
// five bank gates. Assumes bank_phase_in comes from dividers on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module clock_bank_disable_control (
  input  wire  logic                                          sys_clk,
  input  wire  logic                                          rst_n,
  input  wire  logic [clk_bank_pkg::NUM_BANKS-1:0]            bank_disable_in,
  input  wire  logic                                          feedback_bank_disable_in,
  input  wire  logic                                          output_mode_high_in,
  input  wire  logic                                          output_mode_mid_in,
  input  wire  logic                                          ref_test_level_in,
  input  wire  logic [clk_bank_pkg::ALL_BANKS-1:0]            bank_phase_in,
  input  wire  logic [clk_bank_pkg::NUM_BANKS-1:0][clk_bank_pkg::BANK_OUTS-1:0] output_invert,
  input  wire  clk_bank_pkg::lvl_t [clk_bank_pkg::NUM_BANKS-1:0][1:0] bank_skew_select,
  input  wire  clk_bank_pkg::lvl_t                            feedback_skew_select,
  input  wire  clk_bank_pkg::lvl_t [clk_bank_pkg::ALL_BANKS-1:0][1:0] bank_divide_select,
  output var   logic [clk_bank_pkg::NUM_BANKS-1:0][clk_bank_pkg::BANK_OUTS-1:0] bank_clk_out,
  output var   logic [clk_bank_pkg::NUM_BANKS-1:0][clk_bank_pkg::BANK_OUTS-1:0] bank_clk_oe_n,
  output var   logic [clk_bank_pkg::FB_OUTS-1:0]              feedback_clk_out,
  output var   logic [clk_bank_pkg::FB_OUTS-1:0]              feedback_clk_oe_n,
  output var   clk_bank_pkg::skew_t [clk_bank_pkg::ALL_BANKS-1:0] skew_offset_tu,
  output var   logic [clk_bank_pkg::ALL_BANKS-1:0]            bank_at_nominal,
  output var   logic                                          factory_test_active
);

  typedef struct packed {
    logic [clk_bank_pkg::ALL_BANKS-1:0]                dis_meta;
    logic [clk_bank_pkg::ALL_BANKS-1:0]                dis_sync;
    logic [2:0]                                        pin_meta;
    logic [2:0]                                        pin_sync;
    clk_bank_pkg::skew_t [clk_bank_pkg::ALL_BANKS-1:0] skew;
    logic [clk_bank_pkg::ALL_BANKS-1:0]                nominal;
    logic                                              test;
  } top_s;

  top_s st_q;
  top_s st_d;

  clk_bank_pkg::skew_t [clk_bank_pkg::ALL_BANKS-1:0] own_skew;
  logic [clk_bank_pkg::ALL_BANKS-1:0][clk_bank_pkg::BANK_OUTS-1:0] gate_q;
  logic [clk_bank_pkg::ALL_BANKS-1:0][clk_bank_pkg::BANK_OUTS-1:0] gate_oe_n;
  logic [clk_bank_pkg::FB_OUTS-1:0] fb_q;
  logic [clk_bank_pkg::FB_OUTS-1:0] fb_oe_n;

  // Absolute skew of each bank before the feedback reference is removed.
  always_comb begin
    own_skew = '0;
    for (int b = 0; b < 2; b++) begin
      own_skew[b] = clk_bank_pkg::skew_t'(clk_bank_pkg::SKEW_NEAR_BASE
        + clk_bank_pkg::skew_t'(clk_bank_pkg::skew_index(bank_skew_select[b][1],
                                                          bank_skew_select[b][0])));
    end
    for (int b = 2; b < clk_bank_pkg::NUM_BANKS; b++) begin
      if (bank_skew_select[b][1] == clk_bank_pkg::LVL_MID
          && bank_skew_select[b][0] == clk_bank_pkg::LVL_LOW) begin
        own_skew[b] = own_skew[0];
      end else if (bank_skew_select[b][1] == clk_bank_pkg::LVL_MID
                   && bank_skew_select[b][0] == clk_bank_pkg::LVL_HIGH) begin
        own_skew[b] = own_skew[1];
      end else begin
        own_skew[b] = clk_bank_pkg::SKEW_FAR[clk_bank_pkg::skew_index(
                        bank_skew_select[b][1], bank_skew_select[b][0])];
      end
    end
    case (feedback_skew_select)
      clk_bank_pkg::LVL_LOW:  own_skew[clk_bank_pkg::FB_BANK] = clk_bank_pkg::SKEW_FB_LOW;
      clk_bank_pkg::LVL_HIGH: own_skew[clk_bank_pkg::FB_BANK] = clk_bank_pkg::SKEW_FB_HIGH;
      default:                own_skew[clk_bank_pkg::FB_BANK] = clk_bank_pkg::SKEW_ZERO;
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.dis_meta = {feedback_bank_disable_in, bank_disable_in};
    st_d.dis_sync = st_q.dis_meta;
    st_d.pin_meta = {ref_test_level_in, output_mode_mid_in, output_mode_high_in};
    st_d.pin_sync = st_q.pin_meta;
    st_d.test     = st_q.pin_sync[1];
    for (int b = 0; b < clk_bank_pkg::ALL_BANKS; b++) begin
      // Feedback bank is the zero point; every other offset moves with its skew.
      st_d.skew[b] = clk_bank_pkg::skew_t'(own_skew[b]
                                           - own_skew[clk_bank_pkg::FB_BANK]);
      st_d.nominal[b] = (bank_divide_select[b][1] == clk_bank_pkg::LVL_LOW)
                        && (bank_divide_select[b][0] == clk_bank_pkg::LVL_LOW);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Each bank has its own gate, so banks stop and start independently.
  for (genvar b = 0; b < clk_bank_pkg::ALL_BANKS; b++) begin : g_bank
    if (b == clk_bank_pkg::FB_BANK) begin : g_fb
      bank_gate #(
        .N (clk_bank_pkg::FB_OUTS)
      ) u_gate (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .phase        (bank_phase_in[b]),
        .disable_req  (st_q.dis_sync[b]),
        .high_z_style (st_q.pin_sync[0]),
        .test_mode    (st_q.pin_sync[1]),
        .test_level   (st_q.pin_sync[2]),
        .invert       ('0),
        .q            (fb_q),
        .oe_n         (fb_oe_n)
      );
      assign gate_q[b]    = '0;
      assign gate_oe_n[b] = '0;
    end else begin : g_clk
      bank_gate #(
        .N (clk_bank_pkg::BANK_OUTS)
      ) u_gate (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .phase        (bank_phase_in[b]),
        .disable_req  (st_q.dis_sync[b]),
        .high_z_style (st_q.pin_sync[0]),
        .test_mode    (st_q.pin_sync[1]),
        .test_level   (st_q.pin_sync[2]),
        .invert       (output_invert[b]),
        .q            (gate_q[b]),
        .oe_n         (gate_oe_n[b])
      );
    end
  end

  always_comb begin
    for (int b = 0; b < clk_bank_pkg::NUM_BANKS; b++) begin
      bank_clk_out[b]  = gate_q[b];
      bank_clk_oe_n[b] = gate_oe_n[b];
    end
  end

  assign feedback_clk_out    = fb_q;
  assign feedback_clk_oe_n   = fb_oe_n;
  assign skew_offset_tu      = st_q.skew;
  assign bank_at_nominal     = st_q.nominal;
  assign factory_test_active = st_q.test;

endmodule : clock_bank_disable_control

`default_nettype wire
